// File: core/dcdma_engine.v
/*
 Two-channel transfer engine: register port, request selection, channel
 arbitration and a fetch/deposit bus sequencer with a one-word latch.
 Assumes a system bus that answers every cycle in four clocks with
 bus_ack_in, and a processor that flags locked or split sequences.
*/
// Behaviour
// - Two channels move data between any mix of memory and I/O space.
// - Byte or word transfers on wide bus; narrow build forces bytes.
// - Each transfer is one fetch and one deposit, eight clocks minimum.
// - Request comes from pin, timer 2 output or software bit.
// - Per channel 20-bit source and destination, count and control.
// - Count sets number of transfers, up to 65535, with termination.
// - Registers writable anytime; writes apply at once, even mid-transfer; deposit-end pointer and count updates win.
// - Control sync field: destination synchronised adds a gap; unsynchronised and source codes act alike.
// - Optional interrupt request after the last programmed transfer.
// - Option stops at count end or keeps serving regardless.
// - Source pointer steps up, down or stays; memory or I/O.
// - Destination pointer steps up, down or stays; memory or I/O.
// - Higher priority channel wins; equal priority alternates.
// - Transfers beat processor cycles except locked or split words.
// - External bus hold defers any pending transfer.
// - Maskable interrupts do not suspend transfers.
// - Nonmaskable interrupt halts activity on both channels.
// - Destination sync adds idle time after each deposit.
`timescale 1ns/100ps
`include "dcdma_map.vh"

module dcdma_engine #(
	parameter WIDE_BUS = 1
) (
	input  wire        ref_clk_in,
	input  wire        reset_in,
	input  wire [4:0]  reg_addr_in,
	input  wire [15:0] reg_wdata_in,
	input  wire        reg_wr_in,
	input  wire        reg_rd_in,
	output reg  [15:0] reg_rdata_out,
	input  wire [1:0]  channel_request_pins_in,
	input  wire        timer2_out_in,
	input  wire        nmi_in,
	input  wire        cpu_locked_in,
	input  wire        hold_req_in,
	output wire        bus_req_out,
	output reg  [19:0] bus_addr_out,
	output reg         bus_mem_out,
	output reg         bus_write_out,
	output reg         bus_word_out,
	output reg         bus_cycle_out,
	output reg  [15:0] bus_wdata_out,
	input  wire [15:0] bus_rdata_in,
	input  wire        bus_ack_in,
	output wire [1:0]  irq_out
);

	localparam ST_IDLE  = 2'h0;
	localparam ST_FETCH = 2'h1;
	localparam ST_DEPO  = 2'h2;
	localparam ST_GAP   = 2'h3;

	reg  [19:0] src_r [0:1];
	reg  [19:0] dst_r [0:1];
	reg  [15:0] cnt_r [0:1];
	reg  [15:0] ctl_r [0:1];
	reg  [1:0]  irq_r;
	reg  [1:0]  done_r;
	reg  [1:0]  state_r;
	reg         ch_r;
	reg         last_r;
	reg  [2:0]  gap_r;
	reg  [15:0] latch_r;
	reg  [1:0]  pin_s1_r;
	reg  [1:0]  pin_s2_r;
	reg         tmr_s1_r;
	reg         tmr_s2_r;
	reg         nmi_s1_r;
	reg         nmi_s2_r;
	reg  [1:0]  tmr_pend_r;
	reg         tmr_prev_r;

	reg  [1:0]  req;
	reg         pick;
	reg         go;
	integer     i;

	wire        wsel = reg_addr_in[`DCDMA_CH_BIT];
	wire [2:0]  widx = reg_addr_in[2:0];
	wire        wr_src_lo = reg_wr_in && widx == `DCDMA_REG_SRC_LO;
	wire        wr_src_hi = reg_wr_in && widx == `DCDMA_REG_SRC_HI;
	wire        wr_dst_lo = reg_wr_in && widx == `DCDMA_REG_DST_LO;
	wire        wr_dst_hi = reg_wr_in && widx == `DCDMA_REG_DST_HI;
	wire        wr_cnt    = reg_wr_in && widx == `DCDMA_REG_COUNT;
	wire        wr_ctl    = reg_wr_in && widx == `DCDMA_REG_CTRL;
	wire        wr_stat   = reg_wr_in && widx == `DCDMA_REG_STATUS;
	wire        tmr_rise  = tmr_s2_r && !tmr_prev_r;

	function word_of;
		input [15:0] c;
		begin
			word_of = (WIDE_BUS != 0) && c[`DCDMA_C_WORD];
		end
	endfunction

	function [19:0] stepped;
		input [19:0] p;
		input        inc;
		input        dec;
		input        wide;
		reg   [19:0] d;
		begin
			d = wide ? 20'h00002 : 20'h00001;
			if (inc && !dec)
				stepped = p + d;
			else if (dec && !inc)
				stepped = p - d;
			else
				stepped = p;
		end
	endfunction

	// Per-channel request from the chosen source
	always @* begin
		req = 2'h0;
		for (i = 0; i < 2; i = i + 1) begin
			case (ctl_r[i][`DCDMA_C_SRCSEL_HI:`DCDMA_C_SRCSEL_LO])
			`DCDMA_SRC_PIN:   req[i] = pin_s2_r[i];
			`DCDMA_SRC_TIMER: req[i] = tmr_pend_r[i];
			`DCDMA_SRC_SW:    req[i] = ctl_r[i][`DCDMA_C_SWREQ];
			default:          req[i] = 1'b0;
			endcase
			// Count end only blocks when termination is enabled
			if (!ctl_r[i][`DCDMA_C_START] ||
			    (ctl_r[i][`DCDMA_C_TC] && cnt_r[i] == 16'h0000))
				req[i] = 1'b0;
		end
	end

	// Fixed priority when bits differ, else alternate away from last
	always @* begin
		if (req == 2'h3) begin
			if (ctl_r[0][`DCDMA_C_PRIO] != ctl_r[1][`DCDMA_C_PRIO])
				pick = ctl_r[1][`DCDMA_C_PRIO];
			else
				pick = !last_r;
		end else begin
			pick = req[1];
		end
	end

	// Interrupt controller inputs do not appear here at all: the
	// nonmaskable line, bus hold and a locked processor stop the sequencer, at a transfer boundary, never between fetch and deposit.
	always @* begin
		go = (req != 2'h0) && !nmi_s2_r && !hold_req_in
		     && !cpu_locked_in;
	end

	assign bus_req_out = (state_r != ST_IDLE) || go;
	assign irq_out     = irq_r;

	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			pin_s1_r <= 2'h0;
			pin_s2_r <= 2'h0;
			tmr_s1_r <= 1'b0;
			tmr_s2_r <= 1'b0;
			nmi_s1_r <= 1'b0;
			nmi_s2_r <= 1'b0;
			tmr_prev_r <= 1'b0;
		end else begin
			pin_s1_r <= channel_request_pins_in;
			pin_s2_r <= pin_s1_r;
			tmr_s1_r <= timer2_out_in;
			tmr_s2_r <= tmr_s1_r;
			nmi_s1_r <= nmi_in;
			nmi_s2_r <= nmi_s1_r;
			tmr_prev_r <= tmr_s2_r;
		end
	end

	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			for (i = 0; i < 2; i = i + 1) begin
				src_r[i] <= 20'h00000;
				dst_r[i] <= 20'h00000;
				cnt_r[i] <= 16'h0000;
				ctl_r[i] <= 16'h0000;
			end
			irq_r         <= 2'h0;
			done_r        <= 2'h0;
			tmr_pend_r    <= 2'h0;
			state_r       <= ST_IDLE;
			ch_r          <= 1'b0;
			last_r        <= 1'b1;
			gap_r         <= 3'h0;
			latch_r       <= 16'h0000;
			reg_rdata_out <= 16'h0000;
			bus_addr_out  <= 20'h00000;
			bus_mem_out   <= 1'b0;
			bus_write_out <= 1'b0;
			bus_word_out  <= 1'b0;
			bus_cycle_out <= 1'b0;
			bus_wdata_out <= 16'h0000;
		end else begin
			// Register writes first; sequencer updates below override
			// pointers, count and software request bit only for the channel it just served.
			if (wr_src_lo)
				src_r[wsel][15:0] <= reg_wdata_in;
			if (wr_src_hi)
				src_r[wsel][19:16] <= reg_wdata_in[3:0];
			if (wr_dst_lo)
				dst_r[wsel][15:0] <= reg_wdata_in;
			if (wr_dst_hi)
				dst_r[wsel][19:16] <= reg_wdata_in[3:0];
			if (wr_cnt)
				cnt_r[wsel] <= reg_wdata_in;
			if (wr_ctl)
				ctl_r[wsel] <= reg_wdata_in;

			// Timer events latch per channel; set beats clear
			for (i = 0; i < 2; i = i + 1)
				if (tmr_rise)
					tmr_pend_r[i] <= 1'b1;

			// Status write-one-to-clear; a completion in the same
			// cycle is applied later in this block and wins.
			if (wr_stat) begin
				irq_r[wsel]  <= irq_r[wsel] & ~reg_wdata_in[0];
				done_r[wsel] <= done_r[wsel] & ~reg_wdata_in[1];
			end

			if (reg_rd_in) begin
				case (widx)
				`DCDMA_REG_SRC_LO: reg_rdata_out <= src_r[wsel][15:0];
				`DCDMA_REG_SRC_HI:
					reg_rdata_out <= {12'h000, src_r[wsel][19:16]};
				`DCDMA_REG_DST_LO: reg_rdata_out <= dst_r[wsel][15:0];
				`DCDMA_REG_DST_HI:
					reg_rdata_out <= {12'h000, dst_r[wsel][19:16]};
				`DCDMA_REG_COUNT:  reg_rdata_out <= cnt_r[wsel];
				`DCDMA_REG_CTRL:   reg_rdata_out <= ctl_r[wsel];
				`DCDMA_REG_STATUS:
					reg_rdata_out <= {13'h0000, state_r != ST_IDLE,
					                  done_r[wsel], irq_r[wsel]};
				default:           reg_rdata_out <= 16'h0000;
				endcase
			end

			case (state_r)
			ST_IDLE: begin
				if (go) begin
					ch_r          <= pick;
					last_r        <= pick;
					state_r       <= ST_FETCH;
					bus_cycle_out <= 1'b1;
					bus_write_out <= 1'b0;
					bus_addr_out  <= src_r[pick];
					bus_mem_out   <= ctl_r[pick][`DCDMA_C_SMEM];
					bus_word_out  <= word_of(ctl_r[pick]);
					if (ctl_r[pick][`DCDMA_C_SRCSEL_HI:`DCDMA_C_SRCSEL_LO]
					    == `DCDMA_SRC_TIMER)
						tmr_pend_r[pick] <= tmr_rise;
				end
			end
			ST_FETCH: begin
				if (bus_ack_in) begin
					latch_r       <= bus_rdata_in;
					bus_wdata_out <= bus_rdata_in;
					bus_write_out <= 1'b1;
					bus_addr_out  <= dst_r[ch_r];
					bus_mem_out   <= ctl_r[ch_r][`DCDMA_C_DMEM];
					bus_word_out  <= word_of(ctl_r[ch_r]);
					state_r       <= ST_DEPO;
				end
			end
			ST_DEPO: begin
				if (bus_ack_in) begin
					bus_cycle_out <= 1'b0;
					bus_write_out <= 1'b0;
					src_r[ch_r] <= stepped(src_r[ch_r],
						ctl_r[ch_r][`DCDMA_C_SINC],
						ctl_r[ch_r][`DCDMA_C_SDEC],
						word_of(ctl_r[ch_r]));
					dst_r[ch_r] <= stepped(dst_r[ch_r],
						ctl_r[ch_r][`DCDMA_C_DINC],
						ctl_r[ch_r][`DCDMA_C_DDEC],
						word_of(ctl_r[ch_r]));
					cnt_r[ch_r] <= cnt_r[ch_r] - 16'h0001;
					ctl_r[ch_r][`DCDMA_C_SWREQ] <= 1'b0;
					if (cnt_r[ch_r] == 16'h0001) begin
						done_r[ch_r] <= 1'b1;
						if (ctl_r[ch_r][`DCDMA_C_INTEN])
							irq_r[ch_r] <= 1'b1;
					end
					// Destination sync leaves the peripheral time to drop
					// its request, costing throughput.
					if (ctl_r[ch_r][`DCDMA_C_SYNC_HI:`DCDMA_C_SYNC_LO]
					    == `DCDMA_SYNC_DST) begin
						gap_r   <= `DCDMA_DST_GAP;
						state_r <= ST_GAP;
					end else begin
						state_r <= ST_IDLE;
					end
				end
			end
			ST_GAP: begin
				if (gap_r <= 3'h1)
					state_r <= ST_IDLE;
				gap_r <= gap_r - 3'h1;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

endmodule // dcdma_engine

// File: inc/dcdma_map.vh
/*
 Register offsets, control field positions and timing constants of the
 two-channel transfer engine. Assumes a word-wide register port with a
 five-bit register index.
*/
`ifndef DCDMA_MAP_VH
`define DCDMA_MAP_VH

// Register index within a channel, channel select in bit 3
`define DCDMA_REG_SRC_LO   3'h0
`define DCDMA_REG_SRC_HI   3'h1
`define DCDMA_REG_DST_LO   3'h2
`define DCDMA_REG_DST_HI   3'h3
`define DCDMA_REG_COUNT    3'h4
`define DCDMA_REG_CTRL     3'h5
`define DCDMA_REG_STATUS   3'h6
`define DCDMA_CH_BIT       3

// Control register fields
`define DCDMA_C_START      0
`define DCDMA_C_SWREQ      1
`define DCDMA_C_WORD       2
`define DCDMA_C_TC         3
`define DCDMA_C_INTEN      4
`define DCDMA_C_PRIO       5
`define DCDMA_C_SYNC_LO    6
`define DCDMA_C_SYNC_HI    7
`define DCDMA_C_SRCSEL_LO  8
`define DCDMA_C_SRCSEL_HI  9
`define DCDMA_C_SINC       10
`define DCDMA_C_SDEC       11
`define DCDMA_C_SMEM       12
`define DCDMA_C_DINC       13
`define DCDMA_C_DDEC       14
`define DCDMA_C_DMEM       15

// Synchronisation modes
`define DCDMA_SYNC_NONE    2'h0
`define DCDMA_SYNC_SRC     2'h1
`define DCDMA_SYNC_DST     2'h2

// Request source select
`define DCDMA_SRC_PIN      2'h0
`define DCDMA_SRC_TIMER    2'h1
`define DCDMA_SRC_SW       2'h2

// Bus cycle length in clocks; two bus cycles make one transfer
`define DCDMA_BUS_CLKS     3'h4
// Idle clocks after a destination-synchronised deposit
`define DCDMA_DST_GAP      3'h2

`endif

// File: testbench/dcdma_bus_model.sv
/* Bus partner: memory and I/O space answering each engine bus cycle
   after a set latency. Assumes one engine bus cycle at a time. */
`timescale 1ns/100ps
module dcdma_bus_model (
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire [3:0]  lat_in,
	input  wire        cyc_in,
	input  wire        wr_in,
	input  wire        mem_in,
	input  wire        word_in,
	input  wire [19:0] addr_in,
	input  wire [15:0] wdata_in,
	output reg         ack_out,
	output wire [15:0] rdata_out,
	output reg  [15:0] wr_cnt_out,
	output reg  [21:0] last_wa_out,
	output reg  [15:0] last_wd_out
);
	reg  [3:0]  cnt_r;
	wire [15:0] val = addr_in[15:0] ^ {15'h0, mem_in} ^ 16'h3c5a;
	// Read data hold only in the ack cycle; elsewhere the inverse
	assign rdata_out = ack_out ? val : ~val;
	always @(posedge clk_in) begin
		if (rst_in) begin
			ack_out     <= 1'h0;
			cnt_r       <= 4'h0;
			wr_cnt_out  <= 16'h0;
			last_wa_out <= 22'h0;
			last_wd_out <= 16'h0;
		end else begin
			ack_out <= cyc_in && !ack_out && cnt_r == lat_in - 4'h2;
			cnt_r   <= (!cyc_in || ack_out) ? 4'h0 : cnt_r + 4'h1;
			if (ack_out && wr_in) begin
				wr_cnt_out  <= wr_cnt_out + 16'h1;
				last_wa_out <= {word_in, mem_in, addr_in};
				last_wd_out <= wdata_in;
			end
		end
	end
endmodule // dcdma_bus_model

// File: testbench/dcdma_engine_props.sv
/* Checker on the engine's bus sequencing and blocking inputs.
   Assumes a bus partner that acks no sooner than the fourth clock. */
`timescale 1ns/100ps
module dcdma_engine_props (
	input wire        ref_clk_in,
	input wire        reset_in,
	input wire        nmi_in,
	input wire        cpu_locked_in,
	input wire        hold_req_in,
	input wire [19:0] bus_addr_out,
	input wire        bus_write_out,
	input wire        bus_cycle_out,
	input wire [15:0] bus_wdata_out,
	input wire [15:0] bus_rdata_in,
	input wire        bus_ack_in,
	input wire [1:0]  irq_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (reset_in);
	sequence fetch_end;
		bus_cycle_out && bus_ack_in && !bus_write_out;
	endsequence
	sequence put_end;
		bus_cycle_out && bus_ack_in && bus_write_out;
	endsequence
	AST_EIGHT_CLKS: assert property (
		$rose(bus_cycle_out) |-> !bus_write_out ##0 bus_cycle_out[*8])
		else $error("transfer under eight clocks");
	AST_DEPOSIT: assert property (
		fetch_end |=> bus_write_out && bus_wdata_out == $past(bus_rdata_in))
		else $error("deposit missing or wrong data");
	AST_END: assert property (put_end |=> !bus_cycle_out)
		else $error("third bus cycle in a transfer");
	AST_HOLD: assert property (
		hold_req_in && !bus_cycle_out |=> !bus_cycle_out)
		else $error("transfer started under bus hold");
	AST_LOCK: assert property (
		cpu_locked_in && !bus_cycle_out |=> !bus_cycle_out)
		else $error("transfer split a locked sequence");
	AST_NMI: assert property (
		nmi_in[*3] ##0 !bus_cycle_out |=> !bus_cycle_out)
		else $error("transfer started during nmi");
	AST_NO_SUSPEND: assert property (
		bus_cycle_out && !bus_ack_in |=> bus_cycle_out &&
		$stable(bus_addr_out) && $stable(bus_write_out))
		else $error("bus cycle dropped before ack");
	AST_IRQ: assert property (
		$rose(irq_out[0]) || $rose(irq_out[1]) |->
		$past(bus_cycle_out) && $past(bus_ack_in) && $past(bus_write_out))
		else $error("irq without completed deposit");
endmodule // dcdma_engine_props

bind dcdma_engine dcdma_engine_props u_props (.ref_clk_in, .reset_in,
	.nmi_in, .cpu_locked_in, .hold_req_in, .bus_addr_out,
	.bus_write_out, .bus_cycle_out, .bus_wdata_out, .bus_rdata_in,
	.bus_ack_in, .irq_out);

// File: testbench/tb.sv
/* Bench for the two-channel engine: register tasks, bus partner and
   directed transfer sequences. Assumes the chosen register map. */
`timescale 1ns/100ps
module tb;
	reg         clk = 1'h0, rst = 1'h1, we = 1'h0, re = 1'h0, tmr = 1'h0;
	reg  [1:0]  pin = 2'h0;
	reg  [2:0]  blk = 3'h0;
	reg  [3:0]  lat = 4'h4;
	reg  [4:0]  ra = 5'h0;
	reg  [15:0] wd = 16'h0;
	wire [15:0] rdat, wdat, brd, wc, lwd;
	wire [19:0] ad;
	wire [21:0] lwa;
	wire        mem, wr, wrd, cyc, ack;
	wire [1:0]  irq;
	integer     bad_count = 0, compares = 0, nw = 0, j, k;
	initial forever #5 clk = ~clk;
	dcdma_engine #(.WIDE_BUS(1)) uut (.ref_clk_in(clk), .reset_in(rst),
		.reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(we),
		.reg_rd_in(re), .reg_rdata_out(rdat),
		.channel_request_pins_in(pin), .timer2_out_in(tmr),
		.nmi_in(blk[0]), .cpu_locked_in(blk[1]), .hold_req_in(blk[2]),
		.bus_req_out(), .bus_addr_out(ad), .bus_mem_out(mem),
		.bus_write_out(wr), .bus_word_out(wrd), .bus_cycle_out(cyc),
		.bus_wdata_out(wdat), .bus_rdata_in(brd), .bus_ack_in(ack),
		.irq_out(irq));
	dcdma_bus_model bus (.clk_in(clk), .rst_in(rst), .lat_in(lat),
		.cyc_in(cyc), .wr_in(wr), .mem_in(mem), .word_in(wrd),
		.addr_in(ad), .wdata_in(wdat), .ack_out(ack), .rdata_out(brd),
		.wr_cnt_out(wc), .last_wa_out(lwa), .last_wd_out(lwd));
	task print_verdict;
		if (bad_count == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input [21:0] got, input [21:0] exp); begin
		compares = compares + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	end endtask
	// Idle cycle after each strobe keeps one assignment per time step
	task w(input [4:0] a, input [15:0] d); begin
		ra <= a;
		wd <= d;
		we <= 1'h1;
		@(posedge clk) we <= 1'h0;
		@(posedge clk);
	end endtask
	task r(input [4:0] a, input [15:0] e); begin
		ra <= a;
		re <= 1'h1;
		@(posedge clk) re <= 1'h0;
		#1 chk(rdat, e);
		@(posedge clk);
	end endtask
	task wn(input integer d); begin
		nw = nw + d;
		for (j = 0; j < 800 && wc !== nw[15:0]; j = j + 1) @(posedge clk);
		chk(wc, nw[15:0]);
		if (wc !== nw[15:0]) print_verdict;
	end endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		r(5'h05, 16'h0);
		r(5'h07, 16'h0);
		w(5'h01, 16'hffff);
		r(5'h01, 16'h000f);
		w(5'h00, 16'h1234);
		w(5'h02, 16'h0100);
		w(5'h04, 16'h0001);
		w(5'h05, 16'h561f);
		wn(1);
		chk(lwa, {2'h2, 20'h00100});
		chk(lwd, 16'h2e6f);
		r(5'h00, 16'h1236);
		r(5'h02, 16'h00fe);
		r(5'h04, 16'h0);
		r(5'h06, 16'h0003);
		chk(irq, 2'h1);
		w(5'h06, 16'h0003);
		r(5'h06, 16'h0);
		for (k = 0; k < 3; k = k + 1) begin
			blk <= 3'h1 << k;
			w(5'h04, 16'h0001);
			w(5'h05, 16'h561f);
			repeat (20) @(posedge clk);
			chk(wc, nw[15:0]);
			blk <= 3'h0;
			wn(1);
		end
		// Slow partner; pins stay up, count end must stop each channel
		lat <= 4'h7;
		w(5'h04, 16'h0002);
		w(5'h0c, 16'h0002);
		w(5'h05, 16'h9009);
		w(5'h0d, 16'h9029);
		pin <= 2'h3;
		wn(2);
		r(5'h04, 16'h0002);
		r(5'h0c, 16'h0);
		wn(2);
		repeat (30) @(posedge clk);
		chk(wc, nw[15:0]);
		pin <= 2'h0;
		repeat (3) @(posedge clk);
		w(5'h04, 16'h0002);
		w(5'h0c, 16'h0002);
		w(5'h0d, 16'h9009);
		pin <= 2'h3;
		wn(2);
		r(5'h04, 16'h0001);
		r(5'h0c, 16'h0001);
		wn(2);
		w(5'h05, 16'h9001);
		wn(3);
		w(5'h05, 16'h0);
		pin <= 2'h0;
		repeat (40) @(posedge clk);
		nw = wc;
		w(5'h04, 16'h0001);
		w(5'h05, 16'h9109);
		tmr <= 1'h1;
		repeat (3) @(posedge clk);
		tmr <= 1'h0;
		wn(1);
		repeat (30) @(posedge clk);
		chk(wc, nw[15:0]);
		// Destination sync: two idle clocks stretch the 9-clock period
		lat <= 4'h4;
		w(5'h04, 16'h0002);
		w(5'h05, 16'h9089);
		pin <= 2'h1;
		wn(1);
		nw = nw + 1;
		for (j = 0; j < 800 && wc !== nw[15:0]; j = j + 1) @(posedge clk);
		chk(j, 11);
		pin <= 2'h0;
		print_verdict;
	end
endmodule // tb
